/* rtl/spi_input_image.sv */
// Process input image builder with APB access and second comparator
//
// Behaviour
// R1 - The input image is a fixed eight byte block on every exchange.
// R2 - Four image bytes carry the 32-bit word read from the selected register.
// R3 - An accepted read places the full register contents in bytes 0 to 3.
// R4 - Read-refused bit is 0 when the read was accepted and done.
// R5 - A refused read sets read-refused to 1 and zeroes the data bytes.
// R6 - One byte returns the read index 0 to 63 and the read acknowledgement.
// R7 - One byte joins encoder status, write done and write pending.
// R8 - One byte holds position compares, another link status and more compares.
// R9 - Status and error bits follow the present condition without latching.
// R10 - Flags set on their event and hold until the host clears them.
// R11 - Write done reads 0 when the requested write could not be done.
// R12 - Write done reads 1 when the requested write completed.
// R13 - Write request 0 gives write pending 0; next write job is taken.
// R14 - Write request 1 gives write pending 1; a new job is refused.
// R15 - Four encoder status bits are passed into the image.
// R16 - Moving upward is 1 while position rises, else 0.
// R17 - Moving downward is 0 while position rises or stays constant.
// R18 - Second relation is 0 below the compare value, 1 at or above.
// R19 - The host selects the read register by an index 0 to 63.
// R20 - The host sets write request to 1 to write data at the write index.
// R21 - Second compare disabled forces its relation, status and flag to 0.
// R22 - The host clears the second match flag by writing its clear bit 1.
// R23 - Moving downward is 1 while position falls.
// R24 - Every non-retentive image bit is refreshed on each exchange.
//
// Chosen here: the APB register port and the address map.
module spi_input_image
    import spi_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Encoder side
    input  wire logic        pos_valid,
    input  wire logic [31:0] pos_value,
    input  wire logic [3:0]  enc_status,
    input  wire logic        enc_fault,
    // Exchange output
    output logic [63:0]      image_out,
    output logic             image_strobe
);

    // Host output image, held in APB registers
    logic [31:0] out_data_reg;
    logic [31:0] out_ctrl_reg;
    // Exchange timing
    logic [11:0] exch_cnt_reg;
    logic        tick_reg;
    logic        tick_d_reg;
    // Snapshot of the read request
    logic [5:0]  rd_idx_reg;
    // Write handshake
    logic        write_pending;
    logic        write_done_ok;
    logic        wr_accept;
    logic        wr_req;
    logic [5:0]  wr_idx;
    // Encoder state
    logic [31:0] current_position_reg;
    logic [31:0] second_compare_reg;
    logic        moving_upward;
    logic        moving_downward;
    logic        at_or_above_second_compare;
    logic        second_match_now;
    logic        second_match_latched;
    logic        second_compare_enable;
    logic        second_match_clear;
    // Bank read data and image
    logic [31:0] bank_rd_data;
    logic        rd_refused;
    logic [31:0] rd_word;
    logic [63:0] image_next;
    // APB decode
    logic        apb_access;
    logic        apb_done;

    assign wr_req                = out_ctrl_reg[CTL_WR_REQ];
    assign wr_idx                = out_ctrl_reg[CTL_WR_IDX_LSB +: 6];
    assign second_match_clear    = out_ctrl_reg[CTL_CLR2];
    assign second_compare_enable = out_ctrl_reg[CTL_EN2];
    assign apb_access            = psel && penable;
    assign apb_done              = apb_access && pready;

    // Position is read only and the top of the bank is unimplemented
    assign wr_accept = (wr_idx != IDX_POSITION) && (wr_idx < IDX_RESERVED);
    assign rd_refused = (rd_idx_reg >= IDX_RESERVED);

    // APB answers after one wait state so decode never races the data
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= RST_WORD;
        end
        else if (apb_access && !pready)
        begin
            pready  <= 1'b1;
            pslverr <= 1'b0;
            prdata  <= RST_WORD;
            unique case (paddr)
                OFS_OUT_DATA: prdata <= out_data_reg;
                OFS_OUT_CTRL: prdata <= out_ctrl_reg;
                OFS_IN_LOW:   prdata <= image_out[31:0];
                OFS_IN_HIGH:  prdata <= image_out[63:32];
                default:      pslverr <= 1'b1;
            endcase
            if (pwrite && (paddr == OFS_IN_LOW || paddr == OFS_IN_HIGH))
            begin
                pslverr <= 1'b1; // Image words are read only
            end
        end
        else
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Host output image registers, written at the completing edge
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            out_data_reg <= RST_WORD;
            out_ctrl_reg <= RST_WORD;
        end
        else if (apb_done && pwrite)
        begin
            if (paddr == OFS_OUT_DATA)
            begin
                out_data_reg <= pwdata;
            end
            if (paddr == OFS_OUT_CTRL)
            begin
                out_ctrl_reg <= pwdata & CTL_MASK; // R19 R20 R22
            end
        end
    end

    // Exchange cycle divider; one enable pulse per period
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            exch_cnt_reg <= 12'h000;
            tick_reg     <= 1'b0;
            tick_d_reg   <= 1'b0;
        end
        else
        begin
            tick_reg     <= (exch_cnt_reg == EXCH_LAST);
            tick_d_reg   <= tick_reg;
            exch_cnt_reg <= (exch_cnt_reg == EXCH_LAST) ? 12'h000 : exch_cnt_reg + 12'h001;
        end
    end

    // Read index is sampled at the exchange, data follow one cycle later
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rd_idx_reg <= 6'h00;
        end
        else if (tick_reg)
        begin
            rd_idx_reg <= out_ctrl_reg[CTL_RD_IDX_LSB +: 6];
        end
    end

    // Write handshake: a job is taken only when nothing is pending
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            write_pending <= 1'b0;
            write_done_ok <= 1'b0;
        end
        else if (tick_reg)
        begin
            if (!wr_req)
            begin
                write_pending <= 1'b0; // R13
            end
            else if (!write_pending)
            begin
                write_pending <= 1'b1; // R14
                write_done_ok <= wr_accept; // R11 R12
            end
        end
    end

    // Second compare word mirrors bank index two with a reset value
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            second_compare_reg <= RST_WORD;
        end
        else if (tick_reg && wr_req && !write_pending && wr_idx == IDX_SECOND_CMP)
        begin
            second_compare_reg <= out_data_reg;
        end
    end

    spi_reg_bank u_bank (
        .clk_sys (clk_sys),
        .wr_en   (tick_reg && wr_req && !write_pending && wr_accept),
        .wr_idx  (wr_idx),
        .wr_data (out_data_reg),
        .rd_idx  (out_ctrl_reg[CTL_RD_IDX_LSB +: 6]), // Same index the tick samples, so data match it
        .rd_data (bank_rd_data)
    );

    // Position sample and direction; equal samples clear both directions
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            current_position_reg <= RST_WORD;
            moving_upward        <= 1'b0;
            moving_downward      <= 1'b0;
        end
        else if (pos_valid)
        begin
            current_position_reg <= pos_value;
            moving_upward        <= (pos_value > current_position_reg); // R16
            moving_downward      <= (pos_value < current_position_reg); // R17 R23
        end
    end

    // Second comparator status follows the present values
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            at_or_above_second_compare <= 1'b0;
            second_match_now           <= 1'b0;
        end
        else
        begin
            at_or_above_second_compare <= second_compare_enable &&
                                          (current_position_reg >= second_compare_reg); // R18 R21
            second_match_now           <= second_compare_enable &&
                                          (current_position_reg == second_compare_reg); // R9 R21
        end
    end

    // Match flag: a match in the clearing cycle keeps the flag set
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            second_match_latched <= 1'b0;
        end
        else if (!second_compare_enable)
        begin
            second_match_latched <= 1'b0; // R21
        end
        else if (current_position_reg == second_compare_reg)
        begin
            second_match_latched <= 1'b1; // R10
        end
        else if (second_match_clear)
        begin
            second_match_latched <= 1'b0; // R10
        end
    end

    // Read word source: position is live, index two from its mirror
    always_comb
    begin
        if (rd_refused)
        begin
            rd_word = RST_WORD; // R5
        end
        else if (rd_idx_reg == IDX_POSITION)
        begin
            rd_word = current_position_reg; // R3
        end
        else if (rd_idx_reg == IDX_SECOND_CMP)
        begin
            rd_word = second_compare_reg;
        end
        else
        begin
            rd_word = bank_rd_data; // R2 R3
        end
    end

    // Image assembly, eight bytes with unused bits at zero
    always_comb
    begin
        image_next                              = RST_IMAGE; // R1
        image_next[31:0]                        = rd_word;
        image_next[IMG_RD_IDX_LSB +: 6]         = rd_idx_reg; // R6
        image_next[IMG_RD_REFUSED]              = rd_refused; // R4 R5
        image_next[IMG_ENC_LSB +: 4]            = enc_status; // R15 R7
        image_next[IMG_WR_PEND]                 = write_pending; // R7
        image_next[IMG_WR_OK]                   = write_done_ok; // R7
        image_next[IMG_UP]                      = moving_upward; // R8
        image_next[IMG_DOWN]                    = moving_downward;
        image_next[IMG_REL2]                    = at_or_above_second_compare;
        image_next[IMG_NOW2]                    = second_match_now;
        image_next[IMG_LATCH2]                  = second_match_latched;
        image_next[IMG_ENC_FAULT]               = enc_fault; // R8
    end

    // Image refreshed whole on each exchange, strobe marks it
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            image_out    <= RST_IMAGE;
            image_strobe <= 1'b0;
        end
        else
        begin
            image_strobe <= tick_d_reg;
            if (tick_d_reg)
            begin
                image_out <= image_next; // R24 R9
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    a_refused_zero_data: assert property (tick_d_reg && rd_refused |=> // R5
        image_out[IMG_RD_REFUSED] && image_out[31:0] == 32'h0000_0000)
        else $error("refused read left data nonzero");
    a_read_index_echo: assert property (tick_d_reg |=> // R6
        image_out[IMG_RD_IDX_LSB +: 6] == $past(rd_idx_reg) && image_strobe)
        else $error("read index not echoed");
    a_pending_on_req: assert property (tick_reg && wr_req |=> write_pending) // R14
        else $error("pending not raised");
    a_pending_off_req: assert property (tick_reg && !wr_req |=> !write_pending ##1 // R13
        !image_out[IMG_WR_PEND])
        else $error("pending not dropped");
    a_write_done_cause: assert property (tick_reg && wr_req && !write_pending |=> // R11
        write_done_ok == $past(wr_accept))
        else $error("write done wrong");
    a_direction_up: assert property (pos_valid && pos_value > current_position_reg |=> // R16
        moving_upward && !moving_downward)
        else $error("upward not shown");
    a_direction_down: assert property (pos_valid && pos_value < current_position_reg |=> // R23
        moving_downward && !moving_upward)
        else $error("downward not shown");
    a_direction_flat: assert property (pos_valid && pos_value == current_position_reg |=> // R17
        !moving_downward && !moving_upward)
        else $error("constant shows a direction");
    a_relation_value: assert property (second_compare_enable |=> // R18
        at_or_above_second_compare == ($past(current_position_reg) >= $past(second_compare_reg)))
        else $error("relation wrong");
    a_disabled_forced: assert property (!second_compare_enable |=> // R21
        !at_or_above_second_compare && !second_match_now && !second_match_latched)
        else $error("disabled compare not zero");
    a_flag_holds: assert property (second_match_latched && second_compare_enable && // R10
        !second_match_clear |=> second_match_latched)
        else $error("flag lost");

    c_write_taken: cover property (tick_reg && wr_req && !write_pending && wr_accept);
    c_read_refused: cover property (tick_d_reg && rd_refused);
    c_flag_cleared: cover property (second_match_latched ##1 !second_match_latched);
    c_moving_down: cover property (moving_downward);

endmodule

/* rtl/spi_pkg.sv */
// Constants shared by the process input image block and its register bank
package spi_pkg;

    // Image and register bank shape
    localparam int unsigned IMAGE_BYTES    = 8;
    localparam int unsigned IMAGE_BITS     = IMAGE_BYTES * 8;
    localparam int unsigned BANK_WORDS     = 64;
    localparam int unsigned BANK_AW        = 6;
    localparam int unsigned WORD_W         = 32;

    // Bank indices with special meaning
    localparam logic [5:0]  IDX_POSITION   = 6'h00;
    localparam logic [5:0]  IDX_SECOND_CMP = 6'h02;
    localparam logic [5:0]  IDX_RESERVED   = 6'h30;

    // APB byte offsets
    localparam logic [7:0]  OFS_OUT_DATA   = 8'h00;
    localparam logic [7:0]  OFS_OUT_CTRL   = 8'h04;
    localparam logic [7:0]  OFS_IN_LOW     = 8'h08;
    localparam logic [7:0]  OFS_IN_HIGH    = 8'h0c;

    // Control word fields
    localparam int unsigned CTL_RD_IDX_LSB = 0;
    localparam int unsigned CTL_WR_IDX_LSB = 8;
    localparam int unsigned CTL_WR_REQ     = 16;
    localparam int unsigned CTL_CLR2       = 17;
    localparam int unsigned CTL_EN2        = 18;
    localparam logic [31:0] CTL_MASK       = 32'h0007_3f3f;

    // Input image bit positions
    localparam int unsigned IMG_RD_IDX_LSB = 32;
    localparam int unsigned IMG_RD_REFUSED = 38;
    localparam int unsigned IMG_ENC_LSB    = 40;
    localparam int unsigned IMG_WR_PEND    = 46;
    localparam int unsigned IMG_WR_OK      = 47;
    localparam int unsigned IMG_UP         = 48;
    localparam int unsigned IMG_DOWN       = 49;
    localparam int unsigned IMG_REL2       = 50;
    localparam int unsigned IMG_NOW2       = 51;
    localparam int unsigned IMG_LATCH2     = 52;
    localparam int unsigned IMG_ENC_FAULT  = 56;

    // Exchange period
    localparam int unsigned CLK_HZ         = 50_000_000;
    localparam int unsigned EXCH_PERIOD_US = 20;
    localparam int unsigned EXCH_CYCLES    = EXCH_PERIOD_US * (CLK_HZ / 1_000_000);
    localparam logic [11:0] EXCH_LAST      = 12'(EXCH_CYCLES - 1);

    // Reset values
    localparam logic [31:0] RST_WORD       = 32'h0000_0000;
    localparam logic [63:0] RST_IMAGE      = 64'h0000_0000_0000_0000;

endpackage

/* rtl/spi_reg_bank.sv */
// Internal register bank, one write port and one registered read port
module spi_reg_bank
    import spi_pkg::*;
(
    // Clock
    input  wire logic               clk_sys,
    // Write port
    input  wire logic               wr_en,
    input  wire logic [BANK_AW-1:0] wr_idx,
    input  wire logic [WORD_W-1:0]  wr_data,
    // Read port
    input  wire logic [BANK_AW-1:0] rd_idx,
    output logic      [WORD_W-1:0]  rd_data
);

    logic [WORD_W-1:0] mem [BANK_WORDS];

    // Storage has no reset; read is before write on a shared index
    always_ff @(posedge clk_sys)
    begin
        if (wr_en)
        begin
            mem[wr_idx] <= wr_data;
        end
        rd_data <= mem[rd_idx];
    end

endmodule

/* tb/spi_host_model.sv */
// Host side model: APB master that owns the process output words
module spi_host_model
    import spi_pkg::*;
(
    // Clock
    input  wire logic        clk_sys,
    // APB master
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    // APB answer
    input  wire logic        pready
);
    timeunit 1ns;
    timeprecision 1ns;

    // Bus idle at time zero
    initial
    begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0000_0000;
    end

    // Control word: read index, write index, {enable, clear, request}
    function automatic logic [31:0] ctl_word(input logic [5:0] rd, input logic [5:0] wr, input logic [2:0] b);
        return {13'h0000, b, 2'h0, wr, 2'h0, rd};
    endfunction

    // One transfer; the request stands until pready is seen at a rising edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic ok);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // Pready is judged as sampled at each rising edge; release follows that edge
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (pready !== 1'b1 && n < 64);
        ok = (pready === 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        // Released address and data show inverted copies; pwrite keeps its stale value
        paddr   <= ~a;
        pwdata  <= ~d;
        @(posedge clk_sys);
    endtask
endmodule

/* tb/testbench.sv */
// Self-checking bench for the process input image block
module testbench
    import spi_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct {
        logic [31:0] exp;
        logic [31:0] mask;
        logic        err;
        string       what;
    } spi_note_s;

    localparam logic [31:0] HALL   = 32'hffff_ffff;
    localparam logic [31:0] NODONE = 32'hffff_7fff;
    localparam logic [31:0] CMPM   = 32'hffe3_ffff;

    logic        clk_sys;
    logic        rst_b;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic        pready;
    logic        pslverr;
    logic        pos_valid;
    logic        enc_fault;
    logic        image_strobe;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic [31:0] pos_value;
    logic [31:0] seed;
    logic [31:0] d1;
    logic [31:0] cmp;
    logic [31:0] last_data;
    logic [31:0] last_ctrl;
    logic [3:0]  enc_status;
    logic [63:0] image_out;
    spi_note_s   notes[$];
    int          n_errors;
    int          samples_checked;

    // 50 MHz system clock
    always #10 clk_sys = ~clk_sys;

    spi_input_image dut_u (.clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
                           .pslverr, .pos_valid, .pos_value, .enc_status, .enc_fault, .image_out, .image_strobe);

    spi_host_model host_u (.clk_sys, .psel, .penable, .pwrite, .paddr, .pwdata, .pready);

    // Xorshift source, fixed start
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Each finished transfer is judged against the oldest note
    always @(posedge clk_sys)
    begin : judge
        spi_note_s n;
        if (psel && penable && pready === 1'b1)
        begin
            if (notes.size() == 0)
            begin
                n_errors++;
                $display("MISMATCH transfer expected none seen %h", prdata);
            end
            else
            begin
                n = notes.pop_front();
                samples_checked++;
                if ((prdata & n.mask) !== (n.exp & n.mask) || pslverr !== n.err)
                begin
                    n_errors++;
                    $display("MISMATCH %s expected %h/%b seen %h/%b", n.what, n.exp & n.mask, n.err,
                             prdata & n.mask, pslverr);
                end
            end
        end
    end

    // Note the expected answer, then hand the transfer to the host model
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e,
                        input logic [31:0] m, input logic er, input string what);
        logic ok;
        notes.push_back('{e, m, er, what});
        host_u.xfer(w, a, d, ok);
        if (!ok)
        begin
            n_errors++;
            $display("MISMATCH pready expected 1 seen 0");
            end_of_test();
        end
    endtask

    task automatic wait_strobe();
        int n;
        n = 0;
        do
        begin
            @(negedge clk_sys);
            n++;
        end
        while (image_strobe !== 1'b1 && n < 1100);
        if (image_strobe !== 1'b1)
        begin
            n_errors++;
            $display("MISMATCH image_strobe expected 1 seen %b", image_strobe);
            end_of_test();
        end
        @(posedge clk_sys);
    endtask

    // One encoder sample
    task automatic pos(input logic [31:0] v);
        pos_value <= v;
        pos_valid <= 1'b1;
        @(posedge clk_sys);
        pos_valid <= 1'b0;
        @(posedge clk_sys);
    endtask

    // One exchange; f = {latched, now, relation, down, up, done, pending, refused}
    task automatic step(input string t, input logic [31:0] d, input logic [5:0] rd, input logic [5:0] wr,
                        input logic [2:0] b, input logic [31:0] p1, input logic [31:0] p2, input logic [7:0] f,
                        input logic [31:0] hm, input logic [31:0] lo, input logic [31:0] lm);
        logic [31:0] s;
        logic [31:0] c;
        s = rnd();
        c = host_u.ctl_word(rd, wr, b);
        enc_status <= s[3:0];
        enc_fault  <= s[4];
        // A write answers with the word that it replaces
        xfer(1'b1, OFS_OUT_DATA, d, last_data, HALL, 1'b0, "data write");
        last_data = d;
        xfer(1'b1, OFS_OUT_CTRL, c, last_ctrl, HALL, 1'b0, "control write");
        last_ctrl = c & CTL_MASK;
        pos(p1);
        pos(p2);
        wait_strobe();
        xfer(1'b0, OFS_IN_HIGH, 32'h0, {7'h00, s[4], 3'h0, f[7:3], f[2:1], 2'h0, s[3:0], 1'b0, f[0], rd}, hm,
             1'b0, {t, " high"});
        xfer(1'b0, OFS_IN_LOW, 32'h0, lo, lm, 1'b0, {t, " low"});
        $display("test %s done", t);
    endtask

    // Main sequence
    initial
    begin
        clk_sys         = 1'b0;
        rst_b           = 1'b0;
        pos_valid       = 1'b0;
        pos_value       = 32'h0000_0000;
        enc_status      = 4'h0;
        enc_fault       = 1'b0;
        n_errors        = 0;
        samples_checked = 0;
        seed            = 32'hd76c5d6a;
        last_data       = 32'h0000_0000;
        last_ctrl       = 32'h0000_0000;
        repeat (8) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        xfer(1'b0, OFS_IN_LOW, 32'h0, 32'h0, HALL, 1'b0, "reset image low");
        xfer(1'b0, OFS_IN_HIGH, 32'h0, 32'h0, HALL, 1'b0, "reset image high");
        xfer(1'b0, 8'h10, 32'h0, 32'h0, HALL, 1'b1, "unmapped read");
        xfer(1'b1, OFS_IN_HIGH, HALL, 32'h0, HALL, 1'b1, "image write");
        $display("test bus access done");
        wait_strobe();
        d1  = rnd();
        cmp = (rnd() & 32'h0fff_fff0) | 32'h0000_0100;
        step("refused read", d1, 6'h30, 6'h05, 3'b001, 32'h0, 32'h0, 8'h07, HALL, 32'h0, HALL);
        step("busy write", rnd(), 6'h05, 6'h05, 3'b001, 32'h0, 32'h0, 8'h02, NODONE, d1, HALL);
        step("write release", 32'h0, 6'h05, 6'h05, 3'b000, 32'h0, 32'h0, 8'h00, NODONE, d1, HALL);
        step("compare load", cmp, 6'h02, 6'h02, 3'b101, 32'h0, 32'h0, 8'h06, CMPM, cmp, HALL);
        // Clear held here so the match step must set the flag afresh
        step("rising", 32'h0, 6'h02, 6'h02, 3'b110, cmp - 3, cmp + 4, 8'h28, NODONE, cmp, HALL);
        step("match", 32'h0, 6'h02, 6'h00, 3'b101, cmp + 4, cmp, 8'hf2, HALL, cmp, HALL);
        step("flag held", 32'h0, 6'h02, 6'h00, 3'b100, cmp, cmp - 5, 8'h90, NODONE, cmp, HALL);
        step("flag clear", 32'h0, 6'h02, 6'h00, 3'b110, cmp - 5, cmp - 5, 8'h00, NODONE, cmp, HALL);
        step("disabled", 32'h0, 6'h02, 6'h00, 3'b000, cmp + 1, cmp, 8'h10, NODONE, cmp, HALL);
        end_of_test();
    end
endmodule
